// File: inc/padc_pkg.sv
// Package of constants for the pipelined converter output timing block.
package padc_pkg;

  // ************************************************************
  // Data format
  // ************************************************************
  localparam int           DATA_W   = 12;
  localparam logic [11:0]  CODE_MIN = 12'h800;  // Most negative two's complement code.
  localparam logic [11:0]  CODE_MAX = 12'h7ff;  // Most positive two's complement code.
  localparam logic [11:0]  DATA_RST = 12'h000;
  localparam int           SIGN_POS = 11;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS  = 50;
  localparam int CONV_TIME_NS   = 150;
  // Least time: round up to whole cycles.
  localparam int CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIPE_EXTRA     = 2;      // Extra pipeline stages in sample periods.
  localparam int REFRESH_TIME_US = 1000;  // Idle time before a refresh, 1 ms.
  localparam int REFRESH_CYCLES = REFRESH_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int IDLE_W         = 16;

  typedef enum logic [1:0] {PADC_ACTIVE, PADC_IDLE, PADC_REFRESH} padc_state_e;

endpackage : padc_pkg

// File: rtl/padc_core.sv
// Output timing logic of a pipelined sampling converter with idle refresh.
//
// Behaviour
// (RL1) Results always in two's complement.
// (RL2) Offset binary: capture inverts MSB only.
// (RL3) Flag high only at extreme codes.
// (RL4) Rising sample strobe starts conversion.
// (RL5) Started conversion always runs to completion.
// (RL6) Output updates at conversion end, ~150ns.
// (RL7) Result appears two periods plus conversion.
// (RL8) Capture latches on third following edge.
// (RL9) Only rising edges time internal logic.
// (RL10) Sample rate must stay above 20kHz.
// (RL11) Refresh after 1ms without a sample.
// (RL12) Gain select high gives one, low two.
// (RL13) Parallel 12-bit word plus range bit.
// (RL14) Capture registers word and flag together.
module padc_core #(
  parameter int REFRESH_COUNT = padc_pkg::REFRESH_CYCLES  // Idle cycles before a refresh.
) (
  input  wire  logic                         core_clk,          // System clock, 20 MHz.
  input  wire  logic                         reset,             // Synchronous, active high.
  input  wire  logic                         sampleStrobe,      // Conversion clock level.
  input  wire  logic signed [padc_pkg::DATA_W-1:0] sampleValue, // Quantised input at the edge.
  input  wire  logic                         gainSelect,        // High: gain one, low: two.
  output logic [padc_pkg::DATA_W-1:0]        dataOut,           // Result word, two's complement.
  output logic                               outOfRangeFlag,    // High at an extreme code.
  output logic                               signMsbBit,        // Copy of the result MSB.
  output logic                               dataUpdate,        // Pulse when dataOut changes.
  output logic                               refreshPulse       // Pulse on idle refresh.
);
  import padc_pkg::*;

  // ************************************************************
  // Sample edge and input gain
  // ************************************************************
  logic                    strobeQ_q;
  logic                    sampleEdge;
  logic signed [DATA_W:0]  gained;
  logic [DATA_W-1:0]       clipped;

  // Only the rising edge matters, so the strobe duty cycle is free.
  assign sampleEdge = sampleStrobe & ~strobeQ_q;  // RL4 RL9

  // Gain two doubles the input; the result saturates at the extreme codes.
  assign gained  = gainSelect ? {sampleValue[DATA_W-1], sampleValue}  // RL12
                              : {sampleValue, 1'b0};
  assign clipped = (gained > $signed({1'b0, CODE_MAX})) ? CODE_MAX :
                   (gained < $signed({1'b1, CODE_MIN})) ? CODE_MIN :
                   gained[DATA_W-1:0];  // RL1

  always_ff @(posedge core_clk) begin
    if (reset) strobeQ_q <= 1'b0;
    else       strobeQ_q <= sampleStrobe;
  end

  // ************************************************************
  // Pipeline: two sample periods of delay, then a conversion time
  // ************************************************************
  // Each sample edge shifts the stages; the oldest value enters the
  // converter and lands on the outputs CONV_CYCLES later.
  logic [DATA_W-1:0] stage_q [PIPE_EXTRA];
  logic [DATA_W-1:0] convWord_q;
  logic [2:0]        convCnt_q;
  logic              convBusy_q;
  logic              convDone;

  assign convDone = convBusy_q && (convCnt_q == 3'(CONV_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < PIPE_EXTRA; i++) stage_q[i] <= DATA_RST;
    end else if (sampleEdge) begin
      stage_q[0] <= clipped;  // RL4
      for (int i = 1; i < PIPE_EXTRA; i++) stage_q[i] <= stage_q[i-1];  // RL7
    end
  end

  // A conversion in flight is never restarted: a new edge only shifts
  // the stages and the word in the last stage is not converted, which
  // requires the strobe period to be at least the conversion time.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      convBusy_q <= 1'b0;
      convCnt_q  <= 3'h0;
      convWord_q <= DATA_RST;
    end else if (convBusy_q && !convDone) begin
      convCnt_q <= convCnt_q + 3'h1;  // RL5
    end else if (sampleEdge) begin
      convBusy_q <= 1'b1;
      convCnt_q  <= 3'h0;
      convWord_q <= stage_q[PIPE_EXTRA-1];  // RL7
    end else begin
      convBusy_q <= 1'b0;
      convCnt_q  <= 3'h0;
    end
  end

  // ************************************************************
  // Output register
  // ************************************************************
  // Both extreme codes mark an input outside the range. The same decode
  // serves the flag and its check, so the two cannot drift apart.
  function automatic logic isExtreme(input logic [DATA_W-1:0] word);
    return (word == CODE_MIN) || (word == CODE_MAX);
  endfunction

  logic extreme;
  assign extreme = isExtreme(convWord_q);  // RL3

  // Word and flag are updated on the same edge so they stay aligned.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dataOut        <= DATA_RST;
      outOfRangeFlag <= 1'b0;
      dataUpdate     <= 1'b0;
    end else begin
      dataUpdate <= convDone;  // RL6
      if (convDone) begin
        dataOut        <= convWord_q;  // RL6 RL13
        outOfRangeFlag <= extreme;     // RL3
      end
    end
  end

  assign signMsbBit = dataOut[SIGN_POS];  // RL13

  // ************************************************************
  // Idle refresh timer
  // ************************************************************
  padc_state_e       state_q;
  logic [IDLE_W-1:0] idleCnt_q;
  logic              idleExpired;

  assign idleExpired = (idleCnt_q == IDLE_W'(REFRESH_COUNT - 1));
  assign refreshPulse = (state_q == PADC_REFRESH);

  // The timer restarts after every refresh so a stopped strobe refreshes
  // forever, once per interval.
  always_ff @(posedge core_clk) begin
    if (reset || sampleEdge) begin
      state_q   <= PADC_ACTIVE;
      idleCnt_q <= '0;
    end else begin
      case (state_q)
        PADC_ACTIVE, PADC_IDLE: begin
          state_q   <= idleExpired ? PADC_REFRESH : PADC_IDLE;  // RL11
          idleCnt_q <= idleExpired ? '0 : idleCnt_q + IDLE_W'(1);
        end
        PADC_REFRESH: begin
          state_q   <= PADC_IDLE;
          idleCnt_q <= '0;
        end
        default: begin
          state_q   <= PADC_ACTIVE;
          idleCnt_q <= '0;
        end
      endcase
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  // Cycles since the last sample edge or refresh. It is kept apart from the
  // refresh timer so that a miscounting timer shows up against it.
  logic [IDLE_W-1:0] gapCnt_q;

  always_ff @(posedge core_clk) begin
    if (reset || sampleEdge || refreshPulse) gapCnt_q <= '0;
    else                                     gapCnt_q <= gapCnt_q + IDLE_W'(1);
  end

  sequence s_conv_start;
    !convBusy_q ##1 convBusy_q;
  endsequence

  sequence s_edge_then_conv;
    sampleEdge ##1 convBusy_q;
  endsequence

  a_flag_matches_code: assert property (@(posedge core_clk) disable iff (reset)  // RL3
    outOfRangeFlag == isExtreme(dataOut))
    else $error("range flag disagrees with output code");

  a_update_after_conv: assert property (@(posedge core_clk) disable iff (reset)  // RL6
    (sampleEdge && !convBusy_q) |-> ##4 dataUpdate)
    else $error("output not updated at conversion end");

  a_conv_not_aborted: assert property (@(posedge core_clk) disable iff (reset)  // RL5
    s_edge_then_conv |-> convBusy_q [*2])
    else $error("conversion ended early");

  a_data_stable_between: assert property (@(posedge core_clk) disable iff (reset)  // RL13
    !$past(convDone) |-> $stable(dataOut))
    else $error("output changed outside conversion end");

  a_edge_rising_only: assert property (@(posedge core_clk) disable iff (reset)  // RL9
    sampleEdge |-> !$past(sampleStrobe))
    else $error("conversion started without rising edge");

  a_refresh_on_idle: assert property (@(posedge core_clk) disable iff (reset)  // RL11
    refreshPulse |-> !$past(sampleEdge))
    else $error("refresh right after a sample");

  a_stage_shift_seq: assert property (@(posedge core_clk) disable iff (reset)  // RL7
    sampleEdge |=> stage_q[PIPE_EXTRA-1] == $past(stage_q[0]))
    else $error("pipeline stage did not shift");

  a_msb_copy_bit: assert property (@(posedge core_clk) disable iff (reset)  // RL1
    dataUpdate |-> (signMsbBit == dataOut[SIGN_POS]) && (dataOut == $past(convWord_q)))
    else $error("sign bit or word differs from converted word");

  a_conv_duration: assert property (@(posedge core_clk) disable iff (reset)  // RL5 RL6
    s_conv_start |-> convBusy_q [*3] ##1 dataUpdate)
    else $error("conversion length differs from conversion time");

  a_update_single: assert property (@(posedge core_clk) disable iff (reset)  // RL6
    dataUpdate |=> !dataUpdate)
    else $error("update pulse longer than one cycle");

  a_refresh_interval: assert property (@(posedge core_clk) disable iff (reset)  // RL11
    refreshPulse |-> (gapCnt_q == IDLE_W'(REFRESH_COUNT)))
    else $error("refresh not one interval after last activity");

  a_refresh_not_late: assert property (@(posedge core_clk) disable iff (reset)  // RL11
    gapCnt_q <= IDLE_W'(REFRESH_COUNT))
    else $error("idle interval passed without a refresh");

endmodule // padc_core

// File: testbench/padc_capture.sv
// Capture logic model that clocks the converter and latches its words.
module padc_capture (
  input  wire logic        core_clk,       // System clock.
  input  wire logic        reset,          // Clears the model.
  input  wire logic        run,            // Strobes run while high.
  input  wire logic        wide,           // Long high phase when set.
  output logic             sampleStrobe,   // Converter clock level.
  output logic [11:0]      sampleValue,    // Sample stand-in.
  input  wire logic [11:0] dataOut,        // Result word.
  input  wire logic        outOfRangeFlag, // Range flag.
  input  wire logic        dataUpdate      // New word pulse.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] tbl [8] = '{12'h7ff, 12'h800, 12'h000, 12'h3ff, 12'hc01, 12'h7fe, 12'h801, 12'h400};
  logic [11:0] sent [$];
  logic [11:0] capWord, straightWord;
  logic        capFlag, prev = 0;
  int          capIdx, capLag, lag, capCount = 0, phase = 0;
  // A six-cycle period keeps each result clear of the next strobe edge.
  always @(negedge core_clk) begin
    phase = (reset || !run) ? 0 : (phase + 1) % 6;
    sampleStrobe <= run && !reset && (wide ? phase != 5 : phase == 1);
    sampleValue <= tbl[sent.size() % 8];
  end
  // Word and flag are latched together on the third strobe edge after their
  // sample; the first three edges after reset only flush the pipeline.
  always @(posedge core_clk) begin
    lag = lag + 1;
    if (dataUpdate && !reset) capLag = lag;
    if (reset) begin
      sent.delete();
      capCount = 0;
    end else if (sampleStrobe && !prev) begin
      if (sent.size() >= 3) begin
        capWord = dataOut;
        capFlag = outOfRangeFlag;
        straightWord = {~dataOut[11], dataOut[10:0]};
        capIdx = sent.size() - 3;
        capCount++;
      end
      sent.push_back(sampleValue);
      lag = 0;
    end
    prev = sampleStrobe;
  end
endmodule // padc_capture

// File: testbench/tb.sv
// Testbench for the converter output timing block.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import padc_pkg::*;
  logic        core_clk = 0, reset = 1, run = 0, wide = 0, gainSelect = 1;
  logic        sampleStrobe, outOfRangeFlag, signMsbBit, dataUpdate, refreshPulse;
  logic [11:0] sampleValue, dataOut;
  int          fails = 0, cmp_count = 0, pulses = 0;
  // ************************************************************
  // Clock, instances and watchdog
  // ************************************************************
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (refreshPulse === 1'b1) pulses++;
  // A short refresh count keeps the idle test brief.
  padc_core #(.REFRESH_COUNT(8)) i_padc_core (.core_clk(core_clk), .reset(reset),
    .sampleStrobe(sampleStrobe), .sampleValue(sampleValue), .gainSelect(gainSelect),
    .dataOut(dataOut), .outOfRangeFlag(outOfRangeFlag), .signMsbBit(signMsbBit),
    .dataUpdate(dataUpdate), .refreshPulse(refreshPulse));
  padc_capture i_padc_capture (.core_clk(core_clk), .reset(reset), .run(run), .wide(wide),
    .sampleStrobe(sampleStrobe), .sampleValue(sampleValue), .dataOut(dataOut),
    .outOfRangeFlag(outOfRangeFlag), .dataUpdate(dataUpdate));
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
  // ************************************************************
  // Helpers and scenarios
  // ************************************************************
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(string what, logic [11:0] exp, logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Gain two doubles the sample and clips it to the extreme codes.
  function automatic logic [11:0] expv(logic [11:0] v, logic g);
    logic signed [12:0] d;
    d = $signed({v[11], v}) * 13'sd2;
    if (g) return v;
    if (d > 13'sd2047) return CODE_MAX;
    if (d < -13'sd2048) return CODE_MIN;
    return d[11:0];
  endfunction
  // Streams ten results at one gain and duty cycle, then idles.
  task automatic stream(logic g, logic w);
    logic [11:0] e;
    int t;
    reset = 1;
    repeat (6) @(negedge core_clk);
    reset = 0;
    check("dataOut at reset", DATA_RST, dataOut);
    gainSelect = g;
    wide = w;
    run = 1;
    pulses = 0;
    for (int n = 0; n < 10; n++) begin
      t = 0;
      while (i_padc_capture.capCount == n && t < 40) begin
        @(negedge core_clk);
        t++;
      end
      check("capture count", 12'(n + 1), 12'(i_padc_capture.capCount));
      e = expv(i_padc_capture.sent[i_padc_capture.capIdx], g);
      check("dataOut", e, i_padc_capture.capWord);
      check("flag", {11'h0, e == CODE_MIN || e == CODE_MAX}, {11'h0, i_padc_capture.capFlag});
      check("update lag", 12'(CONV_CYCLES + 1), 12'(i_padc_capture.capLag));
      check("straight", {~e[11], e[10:0]}, i_padc_capture.straightWord);
      check("signMsbBit", {11'h0, e[SIGN_POS]}, {11'h0, signMsbBit});
    end
    run = 0;
    check("refresh busy", 12'h0, 12'(pulses));
    repeat (30) @(negedge core_clk);
    check("refresh idle", 12'h1, 12'(pulses > 0));
  endtask
  initial begin
    stream(1'b1, 1'b0);
    stream(1'b0, 1'b1);
    stream(1'b1, 1'b1);
    give_verdict();
  end
endmodule // tb
